//--- verilog/tmc16_pkg.sv
// Package for the 16-bit timer with latch-based byte access.
// Assumes an 8-bit register port with byte addresses as printed.
package tmc16_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] TMC16_ADDR_CAPTURE_LOW = 8'h26;
  localparam logic [7:0] TMC16_ADDR_CAPTURE_HIGH = 8'h27;
  localparam logic [7:0] TMC16_ADDR_COMPARE_B_LOW = 8'h28;
  localparam logic [7:0] TMC16_ADDR_COMPARE_B_HIGH = 8'h29;
  localparam logic [7:0] TMC16_ADDR_COMPARE_A_LOW = 8'h2A;
  localparam logic [7:0] TMC16_ADDR_COMPARE_A_HIGH = 8'h2B;
  localparam logic [7:0] TMC16_ADDR_COUNTER_LOW = 8'h2C;
  localparam logic [7:0] TMC16_ADDR_COUNTER_HIGH = 8'h2D;
  localparam logic [7:0] TMC16_ADDR_CONTROL = 8'h30;
  localparam logic [7:0] TMC16_ADDR_IRQ_STATUS = 8'h31;
  localparam logic [7:0] TMC16_ADDR_IRQ_MASK = 8'h32;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int TMC16_CTRL_RUN_BIT = 0;
  localparam int TMC16_CTRL_EDGE_BIT = 1;
  localparam int TMC16_IRQ_CAPTURE_BIT = 0;
  localparam int TMC16_IRQ_OVERFLOW_BIT = 1;
  localparam logic [15:0] TMC16_WIDE_RESET = 16'h0000;
  localparam logic [7:0] TMC16_BYTE_RESET = 8'h00;

  // Which 16-bit register a byte address belongs to
  typedef enum logic [3:0]
  {
    TMC16_SEL_NONE = 4'b0000,
    TMC16_SEL_CAPTURE = 4'b0001,
    TMC16_SEL_COMPARE_B = 4'b0010,
    TMC16_SEL_COMPARE_A = 4'b0100,
    TMC16_SEL_COUNTER = 4'b1000
  } tmc16_sel_type;

endpackage

//--- verilog/tmc16_capture_sync.sv
// Capture pin synchroniser and selected-edge detector.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ps
module tmc16_capture_sync
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and edge choice
  input wire logic pin_i,
  input wire logic rising_i,
  // Detected edge
  output logic edge_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign edge_o = rising_i ? (sync_r & ~prev_r) : (~sync_r & prev_r);
endmodule

//--- verilog/tmc16_timer.sv
// 16-bit timer with two compare registers and an input capture register,
// accessed as byte pairs through one shared byte latch.
// Assumes a CPU-side byte port with one-cycle strobes, read data next cycle.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module tmc16_timer
  import tmc16_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Timer clock ticks from the source selector
  input wire logic timer_tick_i,
  // Capture pin
  input wire logic capture_pin_i,
  // Status outputs
  output logic capture_flag_o,
  output logic [15:0] compare_a_o,
  output logic [15:0] compare_b_o,
  output logic [15:0] wide_counter_o,
  output logic irq_o
);
  import tmc16_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic tmc16_sel_type sel_of(input logic [7:0] addr);
    case (addr)
      TMC16_ADDR_CAPTURE_LOW,
      TMC16_ADDR_CAPTURE_HIGH: sel_of = TMC16_SEL_CAPTURE;
      TMC16_ADDR_COMPARE_B_LOW,
      TMC16_ADDR_COMPARE_B_HIGH: sel_of = TMC16_SEL_COMPARE_B;
      TMC16_ADDR_COMPARE_A_LOW,
      TMC16_ADDR_COMPARE_A_HIGH: sel_of = TMC16_SEL_COMPARE_A;
      TMC16_ADDR_COUNTER_LOW,
      TMC16_ADDR_COUNTER_HIGH: sel_of = TMC16_SEL_COUNTER;
      default: sel_of = TMC16_SEL_NONE;
    endcase
  endfunction

  tmc16_sel_type sel;
  logic is_high;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic rd_high;

  // In each pair the high byte sits at the odd address
  assign sel = sel_of(reg_addr_i);
  assign is_high = reg_addr_i[0];
  assign wr_low = reg_wr_i && (sel != TMC16_SEL_NONE) && !is_high;
  assign wr_high = reg_wr_i && (sel != TMC16_SEL_NONE) && is_high;
  assign rd_low = reg_rd_i && (sel != TMC16_SEL_NONE) && !is_high;
  assign rd_high = reg_rd_i && (sel != TMC16_SEL_NONE) && is_high;

  // ----------------------------------------
  // Control and interrupt registers
  // ----------------------------------------
  logic run_r;
  logic edge_rising_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic ctrl_wr;
  logic stat_wr;
  logic mask_wr;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == TMC16_ADDR_CONTROL);
  assign stat_wr = reg_wr_i && (reg_addr_i == TMC16_ADDR_IRQ_STATUS);
  assign mask_wr = reg_wr_i && (reg_addr_i == TMC16_ADDR_IRQ_MASK);

  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      run_r <= 1'b0;
      edge_rising_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      run_r <= reg_wdata_i[TMC16_CTRL_RUN_BIT];
      edge_rising_r <= reg_wdata_i[TMC16_CTRL_EDGE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq_mask_r <= 2'h0;
    end
    else if (mask_wr)
    begin
      irq_mask_r <= reg_wdata_i[1:0];
    end
  end

  // ----------------------------------------
  // Shared byte latch
  // ----------------------------------------
  logic [7:0] latch_r;
  logic [15:0] counter_r;
  logic [15:0] compare_a_r;
  logic [15:0] compare_b_r;
  logic [15:0] capture_r;
  logic [15:0] rd_word;
  logic [15:0] merged;

  always_comb
  begin
    case (sel)
      TMC16_SEL_CAPTURE: rd_word = capture_r;
      TMC16_SEL_COMPARE_B: rd_word = compare_b_r;
      TMC16_SEL_COMPARE_A: rd_word = compare_a_r;
      TMC16_SEL_COUNTER: rd_word = counter_r;
      default: rd_word = TMC16_WIDE_RESET;
    endcase
  end

  assign merged = {latch_r, reg_wdata_i};

  // One latch for all four registers
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      latch_r <= TMC16_BYTE_RESET;
    end
    else if (wr_high && sel != TMC16_SEL_CAPTURE)
    begin
      latch_r <= reg_wdata_i;
    end
    else if (rd_low)
    begin
      latch_r <= rd_word[15:8];
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic cnt_wr;
  logic cnt_wrap;

  assign cnt_wr = wr_low && (sel == TMC16_SEL_COUNTER);
  assign cnt_wrap = run_r && timer_tick_i && !cnt_wr &&
    (counter_r == 16'hFFFF);

  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      counter_r <= TMC16_WIDE_RESET;
    end
    else if (cnt_wr)
    begin
      counter_r <= merged;
    end
    else if (run_r && timer_tick_i)
    begin
      counter_r <= counter_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Compare registers
  // ----------------------------------------
  // Compare A via latch merge
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      compare_a_r <= TMC16_WIDE_RESET;
    end
    else if (wr_low && sel == TMC16_SEL_COMPARE_A)
    begin
      compare_a_r <= merged;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      compare_b_r <= TMC16_WIDE_RESET;
    end
    else if (wr_low && sel == TMC16_SEL_COMPARE_B)
    begin
      compare_b_r <= merged;
    end
  end

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  logic capture_edge;

  tmc16_capture_sync u_sync
  (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_r),
    .pin_i(capture_pin_i),
    .rising_i(edge_rising_r),
    .edge_o(capture_edge)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      capture_r <= TMC16_WIDE_RESET;
    end
    else if (capture_edge)
    begin
      capture_r <= counter_r;
    end
  end

  // Set wins over a same-cycle clear so no event is lost
  // Flag with the copy
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq_status_r <= 2'h0;
    end
    else
    begin
      irq_status_r[TMC16_IRQ_CAPTURE_BIT] <= capture_edge ||
        (irq_status_r[TMC16_IRQ_CAPTURE_BIT] &&
         !(stat_wr && reg_wdata_i[TMC16_IRQ_CAPTURE_BIT]));
      irq_status_r[TMC16_IRQ_OVERFLOW_BIT] <= cnt_wrap ||
        (irq_status_r[TMC16_IRQ_OVERFLOW_BIT] &&
         !(stat_wr && reg_wdata_i[TMC16_IRQ_OVERFLOW_BIT]));
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;

  always_comb
  begin
    rdata_nxt = TMC16_BYTE_RESET;
    if (rd_low)
    begin
      rdata_nxt = rd_word[7:0];
    end
    else if (rd_high)
    begin
      rdata_nxt = latch_r;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        TMC16_ADDR_CONTROL: rdata_nxt = {6'h00, edge_rising_r, run_r};
        TMC16_ADDR_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
        TMC16_ADDR_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
        default: rdata_nxt = TMC16_BYTE_RESET;
      endcase
    end
  end

  // Data held only in the cycle after the read
  always_ff @(posedge core_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rdata_r <= TMC16_BYTE_RESET;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign capture_flag_o = irq_status_r[TMC16_IRQ_CAPTURE_BIT];
  assign compare_a_o = compare_a_r;
  assign compare_b_o = compare_b_r;
  assign wide_counter_o = counter_r;
  assign irq_o = |(irq_status_r & irq_mask_r);
endmodule

//--- tb/tmc16_timer_checker.sv
// Checker for the byte-latched timer, bound to tmc16_timer.
// Assumes it sees only the ports of the timer.
`timescale 1ns/1ps
module tmc16_timer_checker
  import tmc16_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Timer side
  input wire logic timer_tick_i,
  input wire logic capture_pin_i,
  input wire logic capture_flag_o,
  input wire logic [15:0] compare_a_o,
  input wire logic [15:0] compare_b_o,
  input wire logic [15:0] wide_counter_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic wl;
  assign wl = reg_wr_i && reg_addr_i == TMC16_ADDR_COUNTER_LOW;
  rdata_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("rdata");
  count_hold_a: assert property (
    !timer_tick_i && !wl |=> $stable(wide_counter_o)) else $error("hold");
  count_step_a: assert property (
    !wl |=> $stable(wide_counter_o) ||
    wide_counter_o == $past(wide_counter_o) + 16'h0001) else $error("step");
  low_merge_a: assert property (
    wl |=> wide_counter_o[7:0] == $past(reg_wdata_i)) else $error("merge");
  high_latch_a: assert property (
    reg_wr_i && reg_addr_i == TMC16_ADDR_COMPARE_A_HIGH
    |=> $stable(compare_a_o)) else $error("high");
  cmp_a_load_a: assert property (
    reg_wr_i && reg_addr_i == TMC16_ADDR_COMPARE_A_LOW
    |=> compare_a_o[7:0] == $past(reg_wdata_i)) else $error("cmp a");
  cmp_b_hold_a: assert property (
    !(reg_wr_i && reg_addr_i == TMC16_ADDR_COMPARE_B_LOW)
    |=> $stable(compare_b_o)) else $error("cmp b");
  cap_edge_a: assert property (
    $rose(capture_flag_o) |-> $past(capture_pin_i, 3) !=
    $past(capture_pin_i, 4)) else $error("edge");
  flag_sticky_a: assert property (
    capture_flag_o && !reg_wr_i |=> capture_flag_o) else $error("flag");
endmodule

bind tmc16_timer tmc16_timer_checker tmc16_timer_checker_inst
(
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .timer_tick_i(timer_tick_i),
  .capture_pin_i(capture_pin_i), .capture_flag_o(capture_flag_o),
  .compare_a_o(compare_a_o), .compare_b_o(compare_b_o),
  .wide_counter_o(wide_counter_o)
);

//--- tb/tmc16_cpu_model.sv
// CPU core model: sole byte master of the timer register port.
// Assumes one caller at a time, so a byte pair is never split.
`timescale 1ns/1ps
module tmc16_cpu_model
(
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial
  begin
    {addr_o, wdata_o, wr_o, rd_o} = 18'h0_0000;
  end
  // Released lines show the inverse, never the stale value
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
    #1;
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge clk_i);
    {addr_o, rd_o} <= {~a, 1'b0};
    #1 d = rdata_i;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr8(a + 8'h01, v[15:8]);
    wr8(a, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 8'h01, v[15:8]);
  endtask
endmodule

//--- tb/test_timer16_capture_access.sv
// Self-checking bench for the byte-latched 16-bit timer.
// Assumes the CPU model is the only driver of the register port.
`timescale 1ns/1ps
module test_timer16_capture_access;
  import tmc16_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tick = 1'b0;
  logic pin = 1'b0;
  logic [7:0] addr, wdata, rdata, b;
  logic wr, rd, flag, irq, t;
  logic [15:0] cmp_a, cmp_b, cnt, v, w;
  integer seed = 32'h5641;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  always #2.5 clk = ~clk;
  tmc16_timer tmc16_timer_inst (.core_clk_i(clk), .rstn_i(rstn),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .timer_tick_i(tick), .capture_pin_i(pin),
    .capture_flag_o(flag), .compare_a_o(cmp_a), .compare_b_o(cmp_b),
    .wide_counter_o(cnt), .irq_o(irq));
  tmc16_cpu_model tmc16_cpu_model_inst (.clk_i(clk), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [15:0] ahead(logic [15:0] s, int k);
    return s + 16'(k);
  endfunction
  // Overflow flag expected when counting past the top
  function automatic logic wraps(logic [15:0] s, int k);
    return (int'(s) + k) > 32'h0000_FFFF;
  endfunction
  // Random ticks, counted as they are sampled
  task automatic tick_run(output int k);
    k = 0;
    repeat (30)
    begin
      @(posedge clk);
      t = 1'($random(seed));
      tick <= t;
      k += t;
    end
    @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial
  begin
    #100000 miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 8'h26; a <= 8'h2E; a++)
    begin
      tmc16_cpu_model_inst.rd8(a[7:0], b);
      chk({8'h00, b}, 16'h0000);
    end
    repeat (4)
    begin
      v = 16'($random(seed));
      tmc16_cpu_model_inst.wr16(TMC16_ADDR_COMPARE_A_LOW, v);
      tmc16_cpu_model_inst.wr16(TMC16_ADDR_COMPARE_B_LOW, ~v);
      tmc16_cpu_model_inst.wr8(TMC16_ADDR_COMPARE_A_HIGH, ~v[15:8]);
      chk(cmp_a, v);
      chk(cmp_b, ~v);
      tmc16_cpu_model_inst.rd16(TMC16_ADDR_COMPARE_A_LOW, w);
      chk(w, v);
      tmc16_cpu_model_inst.wr8(TMC16_ADDR_COMPARE_B_HIGH, v[7:0]);
      tmc16_cpu_model_inst.rd8(TMC16_ADDR_COMPARE_A_HIGH, b);
      chk({8'h00, b}, {8'h00, v[7:0]});
    end
    tmc16_cpu_model_inst.wr16(TMC16_ADDR_COUNTER_LOW, 16'hFFF0);
    tmc16_cpu_model_inst.wr8(TMC16_ADDR_COUNTER_LOW, 8'hFA);
    tick_run(n);
    chk(cnt, 16'hFFFA);
    tmc16_cpu_model_inst.wr8(TMC16_ADDR_CONTROL, 8'h01);
    tick_run(n);
    tmc16_cpu_model_inst.rd16(TMC16_ADDR_COUNTER_LOW, w);
    chk(w, ahead(16'hFFFA, n));
    tmc16_cpu_model_inst.rd8(TMC16_ADDR_IRQ_STATUS, b);
    chk({8'h00, b}, {14'h0000, wraps(16'hFFFA, n), 1'b0});
    for (int e = 1; e >= 0; e--)
    begin
      tmc16_cpu_model_inst.wr8(TMC16_ADDR_IRQ_STATUS, 8'h03);
      tmc16_cpu_model_inst.wr8(TMC16_ADDR_IRQ_MASK, {7'h00, e[0]});
      tmc16_cpu_model_inst.wr8(TMC16_ADDR_CONTROL, {6'h00, e[0], 1'b1});
      v = 16'($random(seed));
      tmc16_cpu_model_inst.wr16(TMC16_ADDR_COUNTER_LOW, v);
      @(posedge clk);
      pin <= e[0];
      repeat (5) @(posedge clk);
      #1 chk({15'h0000, flag}, 16'h0001);
      chk({15'h0000, irq}, {15'h0000, e[0]});
      tmc16_cpu_model_inst.rd16(TMC16_ADDR_CAPTURE_LOW, w);
      chk(w, v);
      tmc16_cpu_model_inst.wr8(TMC16_ADDR_IRQ_STATUS, 8'h01);
      repeat (5) @(posedge clk);
      #1 chk({14'h0000, flag, irq}, 16'h0000);
    end
    give_verdict();
  end
endmodule
